// File: button_detect.sv
`timescale 1ns/100ps
// One channel: press and release around a level with a deadband
module button_detect (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Sample in
  input wire logic sample_valid,
  input wire logic signed [16:0] sensed_value,
  input wire logic signed [15:0] trigger_level,
  input wire logic [5:0] deadband,
  // Detection out
  output logic pressed_ff
);
  logic signed [17:0] value_ext; // Widened to keep the subtraction exact
  logic signed [17:0] release_level; // Level minus deadband
  logic nxt_pressed;

  assign value_ext = {sensed_value[16], sensed_value};
  assign release_level = 18'(trigger_level) - 18'($signed({1'b0, deadband}));

  // Press above the level, release only once below level minus deadband
  always_comb begin
    nxt_pressed = pressed_ff;
    if (sample_valid) begin
      if (!pressed_ff && value_ext > 18'(trigger_level)) begin
        nxt_pressed = 1'b1;
      end else if (pressed_ff && value_ext < release_level) begin
        nxt_pressed = 1'b0;
      end
    end
  end

  // Detection state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pressed_ff <= 1'b0;
    end else begin
      pressed_ff <= nxt_pressed;
    end
  end

  property p_hold_in_band;
    @(posedge core_clk) disable iff (srst)
      (pressed_ff && sample_valid && value_ext >= release_level) |=> pressed_ff;
  endproperty
  a_hold_in_band: assert property (p_hold_in_band) else $error("released inside deadband");
endmodule : button_detect

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // Clock, reset and APB
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // Variant strap and samples
  logic four_channel_strap, sample_valid;
  logic [3:0][15:0] chan_data;
  logic signed [15:0] trigger_level;
  // Outputs under test
  logic button_pin_0, button_pin_1, button_pin_2, button_pin_3;
  logic [2:0] oscillation_divider_exp;
  logic [3:0][4:0] sensor_cycle_count;
  logic [3:0] common_group_mask, bend_group_mask, pins, pressed;
  int error_cnt, cmp_count;
  // Register indices and the bench's copy of their contents
  logic [5:0] idx [9];
  logic [7:0] mirror [9];
  assign pins = {button_pin_3, button_pin_2, button_pin_1, button_pin_0};

  touch_button_algorithm_config i_touch_button_algorithm_config (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .four_channel_strap(four_channel_strap), .sample_valid(sample_valid), .chan_data(chan_data),
    .trigger_level(trigger_level), .button_pin_0(button_pin_0), .button_pin_1(button_pin_1),
    .button_pin_2(button_pin_2), .button_pin_3(button_pin_3),
    .oscillation_divider_exp(oscillation_divider_exp), .sensor_cycle_count(sensor_cycle_count),
    .common_group_mask(common_group_mask), .bend_group_mask(bend_group_mask));

  // Free-running 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Compare and count; an unknown matches only the same unknown
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen at a rising edge
  task apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= addr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check(1'b0, 1'b1, "pready timeout");
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Register write and read-back through the mirror
  task wr(input int i, input logic [7:0] v);
    apb(1'b1, {idx[i], 2'b00}, {24'h0, v});
    mirror[i] = v;
    check(err, 1'b0, "write error");
  endtask : wr

  task rdchk(input int i);
    apb(1'b0, {idx[i], 2'b00}, 32'h0);
    check(rd, {24'h0, mirror[i]}, "read back");
    check(err, 1'b0, "read error");
  endtask : rdchk

  // Drive one sample, predict detector, warp void and pin levels
  task sample(input logic [3:0][15:0] d);
    logic signed [16:0] s;
    logic vd;
    logic [3:0] exp_pins;
    int t;
    @(posedge core_clk);
    sample_valid <= 1'b1;
    chan_data <= d;
    vd = 1'b0;
    t = trigger_level;
    for (int c = 0; c < 4; c++) begin
      s = $signed(d[c]);
      if (!mirror[4][c]) s = -s;
      if (pressed[c]) pressed[c] = !(s < t - 4 * int'(mirror[1][3:0]));
      else pressed[c] = s > t;
      if (mirror[2][2:0] != 3'h0 && s < -4 * int'(mirror[2][2:0])) vd = 1'b1;
    end
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    exp_pins = ~((pressed & {4{~vd}}) ^ mirror[4][7:4]);
    #1 check(pins, exp_pins, "button pins");
  endtask : sample

  task outchk();
    check(oscillation_divider_exp, mirror[0][2:0], "divider exponent");
    check(common_group_mask, mirror[3][7:4], "common group");
    check(bend_group_mask, mirror[3][3:0], "bend group");
    for (int c = 0; c < 4; c++) check(sensor_cycle_count[c], mirror[5 + c][4:0], "cycle count");
  endtask : outchk

  task tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    logic [7:0] m;
    logic [3:0][15:0] d;
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    four_channel_strap = 1'b1; sample_valid = 1'b0; chan_data = '0; trigger_level = 16'sh0064;
    error_cnt = 0; cmp_count = 0; pressed = 4'h0;
    idx = '{touch_cfg_pkg::IDX_SAMPLING_DIVIDER, touch_cfg_pkg::IDX_TRIGGER_DEADBAND,
      touch_cfg_pkg::IDX_CASE_WARP_GUARD, touch_cfg_pkg::IDX_GROUP_ALGORITHM_SELECT,
      touch_cfg_pkg::IDX_PIN_AND_DATA_SENSE, touch_cfg_pkg::IDX_SENSOR_CFG_0,
      touch_cfg_pkg::IDX_SENSOR_CFG_1, touch_cfg_pkg::IDX_SENSOR_CFG_2, touch_cfg_pkg::IDX_SENSOR_CFG_3};
    mirror = '{8'h03, 8'h08, 8'h00, 8'h00, 8'h0F, 8'h04, 8'h04, 8'h04, 8'h04};
    void'($urandom(43));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1 check(pins, 4'hF, "idle pins after reset");
    outchk();
    // Reset values of every register
    for (int i = 0; i < 9; i++) rdchk(i);
    // Unmapped and misaligned accesses are refused and dropped
    apb(1'b0, 8'h74, 32'h0);
    check(rd, 32'h0000_0000, "unmapped read data");
    check(err, 1'b1, "unmapped read error");
    apb(1'b1, 8'h5D, 32'h0000_00FF);
    check(err, 1'b1, "misaligned write");
    rdchk(0);
    // Random back-to-back writes; reserved bits kept zero
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 9; i++) begin
        m = (i == 0 || i == 2) ? 8'h07 : (i == 1 ? 8'h0F : 8'hFF);
        wr(i, 8'($urandom) & m);
      end
      for (int i = 0; i < 9; i++) rdchk(i);
      outchk();
    end
    // Corner samples: just above level, at level, warp trip on one channel
    wr(1, 8'h00); wr(2, 8'h00); wr(4, 8'hFF);
    sample({4{16'h0065}});
    sample({4{16'h0064}});
    wr(2, 8'h01);
    sample({16'h0065, 16'h0065, 16'h0065, 16'hFFFB});
    // Random detection with changing deadband, warp code and senses
    for (int n = 0; n < 60; n++) begin
      wr(1, 8'($urandom_range(0, 15)));
      wr(2, (n % 3 == 0) ? 8'h00 : 8'($urandom_range(1, 7)));
      wr(4, 8'($urandom));
      trigger_level <= 16'($urandom_range(0, 200));
      for (int c = 0; c < 4; c++) d[c] = 16'(int'($urandom_range(0, 600)) - 300);
      sample(d);
    end
    // Two-channel variant: channels 2 and 3 ignore their group and sense settings; the group register still reads back
    four_channel_strap <= 1'b0;
    wr(3, 8'hFF); wr(4, 8'hFF);
    repeat (8) @(posedge core_clk);
    #1 check({common_group_mask, bend_group_mask}, 8'h33, "masks two-channel");
    check(pins[3:2], 2'b11, "pins two-channel");
    rdchk(3);
    tally_and_finish();
  end
endmodule : tb_top

// File: touch_button_algorithm_config.sv
// Our own choice: the APB register port.
`timescale 1ns/100ps
// What this block does
// - Three-bit divider exponent, resets to three
// - Deadband equals four times code, default 32
// - Warp guard off when code is zero
// - Nonzero warp code checks every channel enabled by the variant
// - Any enabled channel too negative voids all buttons
// - Upper nibble selects common group members
// - Lower nibble selects bend group members
// - Upper nibble sets button pin polarity
// - Lower nibble sets channel data sense
// - Channels two, three pins, sense and groups only in four-channel variant
// - Each channel has five-bit cycle count
module touch_button_algorithm_config (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Variant strap pin, high for the four-channel part
  input wire logic four_channel_strap,
  // Channel samples from the converter, same clock
  input wire logic sample_valid,
  input wire logic [3:0][15:0] chan_data,
  input wire logic signed [15:0] trigger_level,
  // Button pins
  output logic button_pin_0,
  output logic button_pin_1,
  output logic button_pin_2,
  output logic button_pin_3,
  // Settings to the converter and algorithms
  output logic [2:0] oscillation_divider_exp,
  output logic [3:0][4:0] sensor_cycle_count,
  output logic [3:0] common_group_mask,
  output logic [3:0] bend_group_mask
);
  localparam int N = touch_cfg_pkg::CHANNELS;

  // Register file
  logic [7:0] divider_ff;
  logic [7:0] deadband_ff;
  logic [7:0] warp_ff;
  logic [7:0] group_ff;
  logic [7:0] sense_ff;
  logic [3:0][7:0] sensor_cfg_ff;
  // Bus answer registers
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  // Strap synchroniser and captured variant
  logic strap_s1_ff;
  logic strap_s2_ff;
  logic strap_s3_ff;
  logic four_ch_ff;
  // Algorithm state
  logic twist_void_ff;
  logic [3:0] pin_ff;
  logic [2:0] div_out_ff;
  logic [3:0][4:0] cyc_out_ff;
  logic [3:0] common_out_ff;
  logic [3:0] bend_out_ff;
  logic [3:0] pressed;

  // Bus decode
  wire [5:0] reg_idx = paddr[7:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire access = psel && penable && !pready_ff;
  wire wr_commit = psel && penable && pready_ff && pwrite;
  wire hit_div = aligned && (reg_idx == touch_cfg_pkg::IDX_SAMPLING_DIVIDER);
  wire hit_db = aligned && (reg_idx == touch_cfg_pkg::IDX_TRIGGER_DEADBAND);
  wire hit_warp = aligned && (reg_idx == touch_cfg_pkg::IDX_CASE_WARP_GUARD);
  wire hit_grp = aligned && (reg_idx == touch_cfg_pkg::IDX_GROUP_ALGORITHM_SELECT);
  wire hit_sense = aligned && (reg_idx == touch_cfg_pkg::IDX_PIN_AND_DATA_SENSE);
  wire [3:0] hit_cfg;
  assign hit_cfg[0] = aligned && (reg_idx == touch_cfg_pkg::IDX_SENSOR_CFG_0);
  assign hit_cfg[1] = aligned && (reg_idx == touch_cfg_pkg::IDX_SENSOR_CFG_1);
  assign hit_cfg[2] = aligned && (reg_idx == touch_cfg_pkg::IDX_SENSOR_CFG_2);
  assign hit_cfg[3] = aligned && (reg_idx == touch_cfg_pkg::IDX_SENSOR_CFG_3);
  wire hit_any = hit_div || hit_db || hit_warp || hit_grp || hit_sense || (|hit_cfg);

  // Read mux, every register is a full byte in the low lane
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_div) begin
      rd_byte = divider_ff;
    end else if (hit_db) begin
      rd_byte = deadband_ff;
    end else if (hit_warp) begin
      rd_byte = warp_ff;
    end else if (hit_grp) begin
      rd_byte = group_ff;
    end else if (hit_sense) begin
      rd_byte = sense_ff;
    end else if (hit_cfg[0]) begin
      rd_byte = sensor_cfg_ff[0];
    end else if (hit_cfg[1]) begin
      rd_byte = sensor_cfg_ff[1];
    end else if (hit_cfg[2]) begin
      rd_byte = sensor_cfg_ff[2];
    end else if (hit_cfg[3]) begin
      rd_byte = sensor_cfg_ff[3];
    end
  end

  // One wait state: answer is registered so the outputs come from flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !hit_any;
      if (access) begin
        prdata_ff <= (pwrite || !hit_any) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
    end
  end
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // Register writes; reserved bits are stored as written, software keeps them zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      divider_ff <= touch_cfg_pkg::RST_SAMPLING_DIVIDER;
      deadband_ff <= touch_cfg_pkg::RST_TRIGGER_DEADBAND;
      warp_ff <= touch_cfg_pkg::RST_CASE_WARP_GUARD;
      group_ff <= touch_cfg_pkg::RST_GROUP_ALGORITHM_SELECT;
      sense_ff <= touch_cfg_pkg::RST_PIN_AND_DATA_SENSE;
    end else if (wr_commit) begin
      if (hit_div) divider_ff <= pwdata[7:0];
      if (hit_db) deadband_ff <= pwdata[7:0];
      if (hit_warp) warp_ff <= pwdata[7:0];
      if (hit_grp) group_ff <= pwdata[7:0];
      if (hit_sense) sense_ff <= pwdata[7:0];
    end
  end

  // Per-channel sensor configuration, one byte each
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cfg
      always_ff @(posedge core_clk) begin
        if (srst) begin
          sensor_cfg_ff[g] <= touch_cfg_pkg::RST_SENSOR_CFG;
        end else if (wr_commit && hit_cfg[g]) begin
          sensor_cfg_ff[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Strap: three flops, variant follows once the last two agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
      strap_s3_ff <= 1'b0;
      four_ch_ff <= 1'b0;
    end else begin
      strap_s1_ff <= four_channel_strap;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (strap_s2_ff == strap_s3_ff) begin
        four_ch_ff <= strap_s3_ff;
      end
    end
  end

  // Channels two and three follow their pin, sense and group settings only on the four-channel part
  wire [3:0] ch_en = {four_ch_ff, four_ch_ff, 2'b11};
  wire [3:0] pin_pol = sense_ff[touch_cfg_pkg::PIN_SENSE_LSB +: 4] & ch_en;
  wire [3:0] val_sense = sense_ff[touch_cfg_pkg::VALUE_SENSE_LSB +: 4] | ~ch_en;
  wire [3:0] common_sel = group_ff[touch_cfg_pkg::COMMON_LSB +: 4] & ch_en;
  wire [3:0] bend_sel = group_ff[touch_cfg_pkg::BEND_LSB +: 4] & ch_en;
  wire [2:0] warp_code = warp_ff[touch_cfg_pkg::WARP_MSB:0];
  wire [3:0] db_code = deadband_ff[touch_cfg_pkg::DEADBAND_MSB:0];
  wire [5:0] deadband_amt = {2'b00, db_code} << touch_cfg_pkg::CODE_STEP_SHIFT;
  wire [4:0] warp_amt = {2'b00, warp_code} << touch_cfg_pkg::CODE_STEP_SHIFT;
  wire warp_on = (warp_code != 3'h0);

  // Sense and warp check per channel
  logic [3:0][16:0] sensed;
  logic [3:0] too_negative;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      wire signed [16:0] raw = {chan_data[g][15], chan_data[g]};
      // Wider than the data so negating full scale cannot wrap
      assign sensed[g] = val_sense[g] ? raw : 17'(-raw);
      // Every channel enabled by the variant is checked, no per-channel selection
      assign too_negative[g] = ch_en[g] &&
        ($signed({sensed[g][16], sensed[g]}) + $signed({13'h0000, warp_amt}) < 18'sh0);
      button_detect u_det (
        .core_clk(core_clk),
        .srst(srst),
        .sample_valid(sample_valid),
        .sensed_value(sensed[g]),
        .trigger_level(trigger_level),
        .deadband(deadband_amt),
        .pressed_ff(pressed[g])
      );
    end
  endgenerate

  // Warp guard verdict, refreshed on every sample
  always_ff @(posedge core_clk) begin
    if (srst) begin
      twist_void_ff <= 1'b0;
    end else if (sample_valid) begin
      twist_void_ff <= warp_on && (|too_negative);
    end
  end

  // Pins: active level per polarity, forced inactive while voided
  wire [3:0] active = pressed & ~{4{twist_void_ff}} & ch_en;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_ff <= 4'hF; // Default polarity is active low, so idle high
    end else begin
      pin_ff <= ~(active ^ pin_pol);
    end
  end
  assign button_pin_0 = pin_ff[0];
  assign button_pin_1 = pin_ff[1];
  assign button_pin_2 = pin_ff[2];
  assign button_pin_3 = pin_ff[3];

  // Settings out, registered so downstream sees clean levels
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_out_ff <= touch_cfg_pkg::RST_SAMPLING_DIVIDER[2:0];
      cyc_out_ff <= {N{touch_cfg_pkg::RST_SENSOR_CFG[4:0]}};
      common_out_ff <= 4'h0;
      bend_out_ff <= 4'h0;
    end else begin
      div_out_ff <= divider_ff[touch_cfg_pkg::DIV_EXP_MSB:0];
      for (int i = 0; i < N; i++) begin
        cyc_out_ff[i] <= sensor_cfg_ff[i][touch_cfg_pkg::CYCLE_MSB:0];
      end
      common_out_ff <= common_sel;
      bend_out_ff <= bend_sel;
    end
  end
  assign oscillation_divider_exp = div_out_ff;
  assign sensor_cycle_count = cyc_out_ff;
  assign common_group_mask = common_out_ff;
  assign bend_group_mask = bend_out_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_div_reset;
    $fell(srst) |-> (divider_ff == touch_cfg_pkg::RST_SAMPLING_DIVIDER) ##1
      (oscillation_divider_exp == touch_cfg_pkg::RST_SAMPLING_DIVIDER[2:0]);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider reset wrong");

  property p_db_reset;
    $fell(srst) |-> (deadband_amt == 6'h20) && (warp_ff == touch_cfg_pkg::RST_CASE_WARP_GUARD);
  endproperty
  a_db_reset: assert property (p_db_reset) else $error("deadband or warp reset wrong");

  property p_readback;
    (psel && penable && pready_ff && !pwrite && hit_div) |-> (prdata[7:0] == divider_ff) && !pslverr;
  endproperty
  a_readback: assert property (p_readback) else $error("read data differs from register");

  property p_write_stores;
    (wr_commit && hit_sense) |=> (sense_ff == $past(pwdata[7:0]));
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write not stored");

  property p_warp_off;
    (sample_valid && warp_code == 3'h0) |=> !twist_void_ff;
  endproperty
  a_warp_off: assert property (p_warp_off) else $error("warp guard acted while off");

  property p_warp_voids;
    (sample_valid && warp_on && too_negative[0]) |=> twist_void_ff ##1 (pin_ff == ~pin_pol);
  endproperty
  a_warp_voids: assert property (p_warp_voids) else $error("buttons not voided");

  property p_pin_low_active;
    (pressed[1] && !twist_void_ff && !pin_pol[1]) |=> !button_pin_1;
  endproperty
  a_pin_low_active: assert property (p_pin_low_active) else $error("pin polarity wrong");

  property p_small_variant;
    !four_ch_ff |=> (common_group_mask[3:2] == 2'b00) && (bend_group_mask[3:2] == 2'b00) && button_pin_2;
  endproperty
  a_small_variant: assert property (p_small_variant) else $error("upper channels active on small part");

  property p_cycle_out;
    (wr_commit && hit_cfg[1]) |=> ##1 (sensor_cycle_count[1] == $past(pwdata[4:0], 2));
  endproperty
  a_cycle_out: assert property (p_cycle_out) else $error("cycle count not passed on");

  property p_sense_neg;
    (!val_sense[0]) |-> (sensed[0] == 17'(-$signed({chan_data[0][15], chan_data[0]})));
  endproperty
  a_sense_neg: assert property (p_sense_neg) else $error("data sense not applied");

  // Bus answers: one-cycle ready, refused writes leave divider, sense and group registers alone
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held longer than one cycle");

  property p_refuse_unmapped;
    (psel && penable && pready_ff && !hit_any) |-> pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_refuse_unmapped: assert property (p_refuse_unmapped) else $error("bad address not refused");

  property p_drop_bad_write;
    (wr_commit && !hit_any) |=> $stable(divider_ff) && $stable(sense_ff) && $stable(group_ff);
  endproperty
  a_drop_bad_write: assert property (p_drop_bad_write) else $error("refused write changed a register");

  property p_pin_high_active;
    (pressed[0] && !twist_void_ff && pin_pol[0]) |=> button_pin_0;
  endproperty
  a_pin_high_active: assert property (p_pin_high_active) else $error("active high pin not driven");

  property p_common_tracks;
    four_ch_ff ##1 $stable(group_ff) |-> (common_group_mask == group_ff[touch_cfg_pkg::COMMON_LSB +: 4]);
  endproperty
  a_common_tracks: assert property (p_common_tracks) else $error("common group mask stale");

  property p_bend_tracks;
    four_ch_ff ##1 $stable(group_ff) |-> (bend_group_mask == group_ff[touch_cfg_pkg::BEND_LSB +: 4]);
  endproperty
  a_bend_tracks: assert property (p_bend_tracks) else $error("bend group mask stale");

  c_write: cover property (wr_commit && hit_warp);
  c_void: cover property (sample_valid && warp_on && (|too_negative));
  c_press: cover property (pressed[0] && !twist_void_ff);
  c_bad_addr: cover property (pslverr);
  c_small_part: cover property (!four_ch_ff && (|group_ff[7:6]));
endmodule : touch_button_algorithm_config

// File: touch_cfg_pkg.sv
package touch_cfg_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_SAMPLING_DIVIDER = 6'h17;
  localparam logic [5:0] IDX_TRIGGER_DEADBAND = 6'h18;
  localparam logic [5:0] IDX_CASE_WARP_GUARD = 6'h19;
  localparam logic [5:0] IDX_GROUP_ALGORITHM_SELECT = 6'h1A;
  localparam logic [5:0] IDX_PIN_AND_DATA_SENSE = 6'h1C;
  localparam logic [5:0] IDX_SENSOR_CFG_0 = 6'h20;
  localparam logic [5:0] IDX_SENSOR_CFG_1 = 6'h22;
  localparam logic [5:0] IDX_SENSOR_CFG_2 = 6'h24;
  localparam logic [5:0] IDX_SENSOR_CFG_3 = 6'h26;
  // Reset values
  localparam logic [7:0] RST_SAMPLING_DIVIDER = 8'h03;
  localparam logic [7:0] RST_TRIGGER_DEADBAND = 8'h08;
  localparam logic [7:0] RST_CASE_WARP_GUARD = 8'h00;
  localparam logic [7:0] RST_GROUP_ALGORITHM_SELECT = 8'h00;
  localparam logic [7:0] RST_PIN_AND_DATA_SENSE = 8'h0F;
  localparam logic [7:0] RST_SENSOR_CFG = 8'h04;
  // Field positions
  localparam int DIV_EXP_MSB = 2;
  localparam int DEADBAND_MSB = 3;
  localparam int WARP_MSB = 2;
  localparam int COMMON_LSB = 4;
  localparam int BEND_LSB = 0;
  localparam int PIN_SENSE_LSB = 4;
  localparam int VALUE_SENSE_LSB = 0;
  localparam int CYCLE_MSB = 4;
  // Codes of deadband and warp guard are in steps of four counts
  localparam int CODE_STEP_SHIFT = 2;
  // Widths
  localparam int CHANNELS = 4;
  localparam int DATA_W = 16;
endpackage : touch_cfg_pkg
